// [src/iep_pkg.sv]
package iep_pkg;

  localparam int IEP_REG_W = 16;
  localparam int IEP_PRIO_W = 3;
  localparam int IEP_NFLD = 15;
  localparam int IEP_NSRC = 16;
  localparam int IEP_SRC_W = 4;
  localparam int IEP_ADDR_W = 8;
  localparam int IEP_NPRIO_REG = 4;

  localparam logic [7:0] IEP_OFS_EN7 = 8'h00;
  localparam logic [7:0] IEP_OFS_PRIO0 = 8'h04;
  localparam logic [7:0] IEP_OFS_PRIO1 = 8'h08;
  localparam logic [7:0] IEP_OFS_PRIO2 = 8'h0C;
  localparam logic [7:0] IEP_OFS_PRIO3 = 8'h10;
  localparam logic [7:0] IEP_OFS_STATUS = 8'h14;
  localparam logic [7:0] IEP_OFS_PEND = 8'h18;

  localparam logic [7:0] IEP_OFS_PRIO [IEP_NPRIO_REG] = '{
    IEP_OFS_PRIO0, IEP_OFS_PRIO1, IEP_OFS_PRIO2, IEP_OFS_PRIO3};

  localparam int IEP_DBG_BIT = 5;
  localparam logic IEP_EN7_RST = 1'b0;
  localparam logic [2:0] IEP_PRIO_RST = 3'h4;
  localparam logic [2:0] IEP_PRIO_OFF = 3'h0;
  localparam logic [2:0] IEP_PRIO_HIGH = 3'h7;
  localparam logic [2:0] IEP_PRIO_LOW = 3'h1;
  localparam int IEP_BYTE_W = 8;

  localparam int IEP_STAT_REQ_BIT = 8;
  localparam int IEP_STAT_LVL_LSB = 4;
  localparam int IEP_STAT_SRC_LSB = 0;

  localparam int IEP_FLD_REG [IEP_NFLD] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3};
  localparam int IEP_FLD_LSB [IEP_NFLD] = '{12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0};

  localparam int IEP_SRC_DEBUG = 15;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [IEP_ADDR_W-1:0] addr;
    logic [IEP_REG_W-1:0] wdata;
    logic [1:0] be;
  } iep_req_s;

  typedef struct packed {
    logic req;
    logic [IEP_PRIO_W-1:0] level;
    logic [IEP_SRC_W-1:0] src;
  } iep_irq_s;

  typedef enum logic [1:0] {
    IEP_S_IDLE = 2'b01,
    IEP_S_DONE = 2'b10
  } iep_state_e;

endpackage

// [src/iep_avmm_slave.sv]
`timescale 1ns/10ps
`default_nettype none
module iep_avmm_slave
  import iep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [IEP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output iep_req_s req,
  input wire logic [IEP_REG_W-1:0] rd_data
);

  iep_state_e state_r;

  // A request is held one cycle with waitrequest high, then completes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IEP_S_IDLE;
    end else begin
      case (state_r)
        IEP_S_IDLE: begin
          if (avs_read || avs_write) begin
            state_r <= IEP_S_DONE;
          end
        end
        IEP_S_DONE: begin
          state_r <= IEP_S_IDLE;
        end
        default: begin
          state_r <= IEP_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(state_r == IEP_S_IDLE && (avs_read || avs_write));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (state_r == IEP_S_IDLE && avs_read) begin
      avs_readdata <= {16'h0000, rd_data};
    end
  end

  // Writes commit on the edge at which the master sees waitrequest low.
  always_comb begin
    req.rd = (state_r == IEP_S_DONE) && avs_read;
    req.wr = (state_r == IEP_S_DONE) && avs_write;
    req.addr = avs_address;
    req.wdata = avs_writedata[IEP_REG_W-1:0];
    req.be = avs_byteenable[1:0];
  end

endmodule
`default_nettype wire

// [src/iep_prio_arbiter.sv]
`timescale 1ns/10ps
`default_nettype none
module iep_prio_arbiter
  import iep_pkg::*;
#(
  parameter int NSRC = IEP_NSRC
)
(
  input wire logic [NSRC*IEP_PRIO_W-1:0] levels,
  output iep_irq_s best
);

  // Strict comparison keeps the lowest source index on a tie.
  always_comb begin
    best.req = 1'b0;
    best.level = IEP_PRIO_OFF;
    best.src = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (levels[i*IEP_PRIO_W +: IEP_PRIO_W] > best.level) begin
        best.req = 1'b1;
        best.level = levels[i*IEP_PRIO_W +: IEP_PRIO_W];
        best.src = IEP_SRC_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// [src/iep_enable_priority_regs.sv]
// Function
// RQ1: Priority fields are three bits; code 111 is level 7, the highest.
// RQ2: Code 001 is level 1, lowest active; other codes map in binary order.
// RQ3: Code 000 disables the source; it never reaches the core.
// RQ4: Reset loads every priority field with 100 and the debug enable with 0.
// RQ5: Unimplemented bits read zero and ignore writes.
// RQ6: Enable register 7 holds only the debug-port enable at bit 5.
// RQ7: Enable one lets a request through; enable zero blocks it.
// RQ8: Priority 0: timer1 14-12, compare1 10-8, capture1 6-4, ext irq0 2-0.
// RQ9: Priority 1: timer2 14-12, compare2 10-8, capture2 6-4, dma0 2-0.
// RQ10: Priority 2: uart1 rx 14-12, spi1 event 10-8, spi1 fault 6-4, timer3 2-0.
// RQ11: Priority 3: bits 15-11 unused; dma1 10-8, adc 6-4, uart1 tx 2-0.
// RQ12: Bits 15, 11, 7 and 3 of each priority register read zero.
// RQ13: The highest pending level goes to the core; ties favour lower index.
`timescale 1ns/10ps
`default_nettype none
module iep_enable_priority_regs
  import iep_pkg::*;
#(
  parameter logic [IEP_PRIO_W-1:0] DBG_PRIORITY = IEP_PRIO_RST
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [IEP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [IEP_NSRC-1:0] irq_flag,
  input wire logic [IEP_NFLD-1:0] irq_src_en,
  output logic irq_req,
  output logic [IEP_PRIO_W-1:0] irq_level,
  output logic [IEP_SRC_W-1:0] irq_src,
  output logic debug_port_irq_enable
);

  iep_req_s bus_req;
  iep_irq_s best;
  logic [IEP_REG_W-1:0] rd_word;
  logic [IEP_PRIO_W-1:0] prio_r [IEP_NFLD];
  logic en7_r;
  logic [IEP_NSRC-1:0] src_en;
  logic [IEP_NSRC-1:0] src_live;
  logic [IEP_NSRC*IEP_PRIO_W-1:0] src_level;
  logic [IEP_NSRC-1:0] pend_r;
  logic en7_hit;
  logic en7_lane;

  iep_avmm_slave u_slave (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .req(bus_req),
    .rd_data(rd_word)
  );

  // Enable register 7: only the debug-port enable is stored.
  assign en7_hit = bus_req.wr && (bus_req.addr == IEP_OFS_EN7);
  assign en7_lane = bus_req.be[IEP_DBG_BIT / IEP_BYTE_W];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en7_r <= IEP_EN7_RST; // [RQ4]
    end else if (en7_hit && en7_lane) begin
      en7_r <= bus_req.wdata[IEP_DBG_BIT]; // [RQ6]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_port_irq_enable <= IEP_EN7_RST;
    end else if (en7_hit && en7_lane) begin
      debug_port_irq_enable <= bus_req.wdata[IEP_DBG_BIT];
    end
  end

  // Priority fields, each held in its own three-bit register.
  generate
    for (genvar f = 0; f < IEP_NFLD; f++) begin : g_fld
      localparam int REG = IEP_FLD_REG[f];
      localparam int LSB = IEP_FLD_LSB[f];
      logic hit;
      logic lane;

      assign hit = bus_req.wr && (bus_req.addr == IEP_OFS_PRIO[REG]);
      assign lane = bus_req.be[LSB / IEP_BYTE_W];

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          prio_r[f] <= IEP_PRIO_RST; // [RQ4]
        end else if (hit && lane) begin
          prio_r[f] <= bus_req.wdata[LSB +: IEP_PRIO_W]; // [RQ1] [RQ8] [RQ9] [RQ10] [RQ11]
        end
      end
    end
  endgenerate

  // Read mux: fields land at their slots, every other bit stays zero.
  always_comb begin
    rd_word = '0; // [RQ5] [RQ12]
    if (bus_req.addr == IEP_OFS_EN7 || avs_address == IEP_OFS_EN7) begin
      rd_word = '0;
    end
    if (avs_address == IEP_OFS_EN7) begin
      rd_word[IEP_DBG_BIT] = en7_r; // [RQ6]
    end
    for (int f = 0; f < IEP_NFLD; f++) begin
      if (avs_address == IEP_OFS_PRIO[IEP_FLD_REG[f]]) begin
        rd_word[IEP_FLD_LSB[f] +: IEP_PRIO_W] = prio_r[f]; // [RQ8] [RQ9] [RQ10] [RQ11]
      end
    end
    if (avs_address == IEP_OFS_STATUS) begin
      rd_word[IEP_STAT_REQ_BIT] = irq_req;
      rd_word[IEP_STAT_LVL_LSB +: IEP_PRIO_W] = irq_level;
      rd_word[IEP_STAT_SRC_LSB +: IEP_SRC_W] = irq_src;
    end
    if (avs_address == IEP_OFS_PEND) begin
      rd_word = pend_r;
    end
  end

  // Per-source gating: flag, enable and a nonzero level are all needed.
  assign src_en = {en7_r, irq_src_en};

  generate
    for (genvar s = 0; s < IEP_NSRC; s++) begin : g_src
      logic [IEP_PRIO_W-1:0] lvl;

      if (s == IEP_SRC_DEBUG) begin : g_dbg
        assign lvl = DBG_PRIORITY;
      end else begin : g_fld_src
        assign lvl = prio_r[s];
      end

      assign src_live[s] = irq_flag[s] && src_en[s] && (lvl != IEP_PRIO_OFF); // [RQ3] [RQ7]
      assign src_level[s*IEP_PRIO_W +: IEP_PRIO_W] = src_live[s] ? lvl : IEP_PRIO_OFF; // [RQ2] [RQ3]
    end
  endgenerate

  iep_prio_arbiter #(
    .NSRC(IEP_NSRC)
  ) u_arb (
    .levels(src_level),
    .best(best)
  );

  // Registered request towards the core.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_level <= IEP_PRIO_OFF;
      irq_src <= '0;
    end else begin
      irq_req <= best.req; // [RQ13]
      irq_level <= best.level; // [RQ1] [RQ2]
      irq_src <= best.src; // [RQ13]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
    end else begin
      pend_r <= src_live;
    end
  end

endmodule
`default_nettype wire

// [test/iep_enable_priority_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module iep_chk
  import iep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [IEP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [IEP_NSRC-1:0] irq_flag,
  input wire logic [IEP_NFLD-1:0] irq_src_en,
  input wire logic irq_req,
  input wire logic [IEP_PRIO_W-1:0] irq_level,
  input wire logic [IEP_SRC_W-1:0] irq_src,
  input wire logic debug_port_irq_enable
);
  logic [15:0] fq_r;
  logic [15:0] eq_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Inputs one edge back, which the request outputs answer to.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fq_r <= 16'h0000;
      eq_r <= 16'h0000;
    end else begin
      fq_r <= irq_flag;
      eq_r <= {debug_port_irq_enable, irq_src_en};
    end
  end
  AST_LVL: assert property (irq_req |-> irq_level != 3'h0)
    else $error("live request at level zero");
  AST_IDLE: assert property (!irq_req |-> irq_level == 3'h0 && irq_src == 4'h0)
    else $error("idle output not zero");
  AST_FLAG: assert property (irq_req |-> fq_r[irq_src])
    else $error("winner had no flag");
  AST_EN: assert property (irq_req |-> eq_r[irq_src])
    else $error("winner was not enabled");
  AST_NOFLAG: assert property (irq_flag == 16'h0000 |=> !irq_req)
    else $error("request without flags");
  AST_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_EN7: assert property (avs_read && !avs_waitrequest && avs_address == IEP_OFS_EN7 |->
    (avs_readdata & 32'hFFFFFFDF) == 32'h0)
    else $error("enable register spare bit set");
  AST_GAPS: assert property (avs_read && !avs_waitrequest && avs_address inside {[8'h04:8'h10]} |->
    (avs_readdata & 32'hFFFF8888) == 32'h0)
    else $error("priority gap bit set");
  AST_P3TOP: assert property (avs_read && !avs_waitrequest && avs_address == IEP_OFS_PRIO3 |->
    avs_readdata[15:11] == 5'h00)
    else $error("priority 3 top bits set");
  AST_RST: assert property ($rose(rst_n) |-> !debug_port_irq_enable && !irq_req)
    else $error("state after reset wrong");
endmodule
bind iep_enable_priority_regs iep_chk u_iep_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_flag(irq_flag), .irq_src_en(irq_src_en),
  .irq_req(irq_req), .irq_level(irq_level), .irq_src(irq_src),
  .debug_port_irq_enable(debug_port_irq_enable));
`default_nettype wire

// [test/iep_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
module iep_src_model
  import iep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [IEP_NSRC-1:0] want,
  output logic [IEP_NSRC-1:0] irq_flag
);
  // Each source holds its flag as a level until it is told otherwise.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag <= 16'h0000;
    end else begin
      irq_flag <= want;
    end
  end
endmodule
`default_nettype wire

// [test/iep_enable_priority_regs_test.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module iep_enable_priority_regs_test
  import iep_pkg::*;
;
  localparam logic [2:0] DBG_LV = 3'h6;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] want = 16'h0000;
  logic [15:0] irq_flag;
  logic [14:0] irq_src_en = 15'h0000;
  logic irq_req;
  logic [2:0] irq_level;
  logic [3:0] irq_src;
  logic debug_port_irq_enable;
  int errors = 0;
  int checks_done = 0;
  int seed = 65835;
  logic [2:0] lv [16];
  logic dbg;
  logic [31:0] r;
  logic [7:0] p;
  always #2 clk_sys = ~clk_sys;
  iep_src_model u_iep_src_model (.clk_sys(clk_sys), .rst_n(rst_n), .want(want), .irq_flag(irq_flag));
  iep_enable_priority_regs #(.DBG_PRIORITY(DBG_LV)) u_iep_enable_priority_regs (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_flag(irq_flag), .irq_src_en(irq_src_en),
    .irq_req(irq_req), .irq_level(irq_level), .irq_src(irq_src),
    .debug_port_irq_enable(debug_port_irq_enable));
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("BAD %0t bus timeout", $time);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [15:0] rv(input int n);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < IEP_NFLD; i++) if (IEP_FLD_REG[i] == n) v[IEP_FLD_LSB[i] +: 3] = lv[i];
    return v;
  endfunction
  // Highest level wins; a strict compare keeps the lowest index on ties.
  function automatic logic [7:0] pick(input logic [15:0] f, input logic [15:0] e);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 16; i++) if (f[i] && e[i] && lv[i] > b[6:4]) b = {1'b1, lv[i], 4'(i)};
    return b;
  endfunction
  task end_sim;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    end_sim;
  end
  initial begin
    lv[15] = DBG_LV;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, IEP_OFS_EN7, 16'h0000, 4'h3);
    `CHK(r, 32'h0)
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, IEP_OFS_PRIO[i], 16'h0000, 4'h3);
      `CHK(r, (i == 3) ? 32'h0444 : 32'h4444)
    end
    for (int i = 0; i < 5; i++) bus(1'b1, 8'(i * 4), 16'hFFFF, 4'h3);
    bus(1'b1, 8'h40, 16'hFFFF, 4'h3);
    bus(1'b0, 8'h40, 16'h0000, 4'h3);
    `CHK(r, 32'h0)
    bus(1'b0, IEP_OFS_EN7, 16'h0000, 4'h3);
    `CHK(r, 32'h20)
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, IEP_OFS_PRIO[i], 16'h0000, 4'h3);
      `CHK(r, (i == 3) ? 32'h0777 : 32'h7777)
    end
    `CHK(debug_port_irq_enable, 1'b1)
    bus(1'b1, IEP_OFS_PRIO0, 16'h0000, 4'h1);
    bus(1'b0, IEP_OFS_PRIO0, 16'h0000, 4'h3);
    `CHK(r, 32'h7700)
    for (int k = 0; k < 64; k++) begin
      for (int i = 0; i < 15; i++) lv[i] = (k == 0) ? 3'h7 : 3'($random(seed));
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, IEP_OFS_PRIO[i], rv(i), 4'h3);
        bus(1'b0, IEP_OFS_PRIO[i], 16'h0000, 4'h3);
        `CHK(r[15:0], rv(i))
      end
      dbg = 1'($random(seed));
      bus(1'b1, IEP_OFS_EN7, {10'h000, dbg, 5'h00}, 4'h3);
      want <= (k == 0) ? 16'hFFFF : 16'($random(seed));
      irq_src_en <= (k == 0) ? 15'h7FFF : 15'($random(seed));
      repeat (3) @(posedge clk_sys);
      p = pick(irq_flag, {dbg, irq_src_en});
      `CHK({irq_req, irq_level, irq_src}, p)
      bus(1'b0, IEP_OFS_STATUS, 16'h0000, 4'h3);
      `CHK(r, {23'h000000, p[7], 1'b0, p[6:0]})
    end
    end_sim;
  end
endmodule
`default_nettype wire
